// ### hdl/usart_pkg.sv
package usart_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_FORMAT = 8'h0c;
  localparam logic [7:0] ADDR_BAUD = 8'h10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ST_RX_COMPLETE = 7;
  localparam int ST_TX_COMPLETE = 6;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_DOUBLE_SPEED = 1;
  localparam int CT_TX_COMPLETE_IE = 6;
  localparam int CT_TX_EMPTY_IE = 5;
  localparam int CT_RX_ENABLE = 4;
  localparam int CT_SIZE_TOP = 2;
  localparam int CT_RX_NINTH = 1;
  localparam int CT_TX_NINTH = 0;
  localparam int CT_TX_ENABLE = 3;
  localparam int FM_SYNC_MODE = 6;
  localparam int FM_PARITY_EN = 5;
  localparam int FM_PARITY_ODD = 4;
  localparam int FM_STOP_TWO = 3;
  localparam int FM_SIZE_HI = 2;
  localparam int FM_SIZE_LO = 1;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [6:0] FORMAT_RST = 7'h06;
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } ahb_req_t;
  typedef struct packed {
    logic sync_mode;
    logic parity_en;
    logic parity_odd;
    logic stop_two;
    logic [3:0] nbits;
  } frame_cfg_t;
endpackage

// ### hdl/usart_tx_rx_framing.sv
// What this block does
// - Transmit enable takes over transmit pin
// - Sync mode: serial clock pin drives transmission
// - Data write loads buffer; moves when shifter free
// - Shifter sends whole frame at baud rate
// - Short characters ignore upper written bits
// - Empty flag tracks buffer; data write clears
// - Empty interrupt requested while flag set
// - Complete flag sets when frame out, buffer empty
// - Complete flag clears on ack or one
// - Complete interrupt requested when flag set
// - Parity bit after data, before stop
// - Disable waits for drain, then releases pin
// - Receive enable takes over receive pin
// - Sync mode: serial clock pin is receive clock
// - Start bit begins reception, bits shifted in
// - Second stop bit ignored by receiver
// - First stop moves frame into receive buffer
// - Short characters read upper bits zero
// - Frame: start low, LSB first, stops high
// - Parity is data xor, inverted when odd
// - Receive flag marks unread; disable flushes
module usart_tx_rx_framing #(
  parameter int BAUD_W = 12
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // AHB-Lite slave
  input wire usart_pkg::ahb_req_t i_ahb,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic [1:0] o_hresp,
  // Serial pins
  output logic o_txd,
  output logic o_txd_oe,
  input wire logic i_rxd,
  output logic o_rxd_owned,
  input wire logic i_xck,
  output logic o_xck,
  output logic o_xck_oe,
  // Interrupt requests
  input wire logic i_global_irq_en,
  input wire logic i_tx_done_irq_taken,
  output logic o_tx_empty_irq,
  output logic o_tx_done_irq
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    if (code == usart_pkg::SIZE_NINE) begin
      return 4'h9;
    end else if (code[2]) begin
      return 4'h8;
    end
    return 4'h5 + {2'h0, code[1:0]};
  endfunction

  function automatic logic [8:0] mask_data(input logic [8:0] d, input logic [3:0] n);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < 9; i++) begin
      m[i] = (i < int'(n)) ? d[i] : 1'b0;
    end
    return m;
  endfunction

  function automatic logic parity_of(input logic [8:0] d, input usart_pkg::frame_cfg_t c);
    return (^mask_data(d, c.nbits)) ^ c.parity_odd;
  endfunction

  function automatic logic [12:0] build_frame(input logic [8:0] d, input usart_pkg::frame_cfg_t c);
    logic [12:0] f;
    logic [8:0] m;
    f = '1;
    m = mask_data(d, c.nbits);
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(c.nbits)) begin
        f[i + 1] = m[i];
      end
    end
    if (c.parity_en) begin
      f[c.nbits + 4'h1] = parity_of(d, c);
    end
    return f;
  endfunction

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  localparam logic [BAUD_W-1:0] BAUD_RST_W = BAUD_W'(usart_pkg::BAUD_RST);
  logic [7:0] ctrl_ff;
  logic [6:0] fmt_ff;
  logic [BAUD_W-1:0] baud_ff;
  logic dbl_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [8:0] tx_buf_ff;
  logic tx_full_ff;
  logic tx_done_ff;
  logic tx_own_ff;
  logic tx_busy_ff;
  logic [3:0] tx_left_ff;
  logic [11:0] tx_sh_ff;
  logic [4:0] tx_os_ff;
  logic [BAUD_W-1:0] baud_cnt_ff;
  logic rx_busy_ff;
  logic [3:0] rx_left_ff;
  logic [10:0] rx_sh_ff;
  logic [4:0] rx_os_ff;
  logic [8:0] rx_buf_ff;
  logic rx_full_ff;
  usart_pkg::frame_cfg_t cfg;
  logic ap_valid;
  logic rd_data;
  logic wr_data;
  logic wr_status;
  logic tick;
  logic [4:0] ovs;
  logic tx_step;
  logic tx_last;
  logic tx_load;
  logic tx_done_set;
  logic [3:0] tx_count;
  logic rx_sample;
  logic rx_start;
  logic rx_done;
  logic [3:0] rx_total;
  logic [10:0] nxt_rx_sh;
  logic [8:0] rx_word;

  assign cfg.sync_mode = fmt_ff[usart_pkg::FM_SYNC_MODE];
  assign cfg.parity_en = fmt_ff[usart_pkg::FM_PARITY_EN];
  assign cfg.parity_odd = fmt_ff[usart_pkg::FM_PARITY_ODD];
  assign cfg.stop_two = fmt_ff[usart_pkg::FM_STOP_TWO];
  assign cfg.nbits = data_bits({ctrl_ff[usart_pkg::CT_SIZE_TOP], fmt_ff[usart_pkg::FM_SIZE_HI:usart_pkg::FM_SIZE_LO]});

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign ap_valid = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;
  assign rd_data = ap_valid && !i_ahb.hwrite && i_ahb.haddr[7:0] == usart_pkg::ADDR_DATA;
  assign wr_data = wr_pend_ff && wr_addr_ff == usart_pkg::ADDR_DATA;
  assign wr_status = wr_pend_ff && wr_addr_ff == usart_pkg::ADDR_STATUS;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      o_hreadyout <= 1'b0;
      o_hresp <= usart_pkg::HRESP_OKAY;
    end else begin
      wr_pend_ff <= ap_valid && i_ahb.hwrite && i_ahb.haddr[31:8] == 24'h000000;
      wr_addr_ff <= i_ahb.haddr[7:0];
      o_hreadyout <= 1'b1;
      o_hresp <= usart_pkg::HRESP_OKAY;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= 32'h00000000;
    end else if (ap_valid && !i_ahb.hwrite) begin
      o_hrdata <= 32'h00000000;
      if (i_ahb.haddr[31:8] != 24'h000000) begin
        o_hrdata <= 32'h00000000;
      end else if (i_ahb.haddr[7:0] == usart_pkg::ADDR_DATA) begin
        o_hrdata[7:0] <= rx_buf_ff[7:0];
      end else if (i_ahb.haddr[7:0] == usart_pkg::ADDR_STATUS) begin
        o_hrdata[usart_pkg::ST_RX_COMPLETE] <= rx_full_ff;
        o_hrdata[usart_pkg::ST_TX_COMPLETE] <= tx_done_ff;
        o_hrdata[usart_pkg::ST_TX_EMPTY] <= !tx_full_ff;
        o_hrdata[usart_pkg::ST_DOUBLE_SPEED] <= dbl_ff;
      end else if (i_ahb.haddr[7:0] == usart_pkg::ADDR_CONTROL) begin
        o_hrdata[7:0] <= {ctrl_ff[7:2], rx_buf_ff[8], ctrl_ff[0]};
      end else if (i_ahb.haddr[7:0] == usart_pkg::ADDR_FORMAT) begin
        o_hrdata[6:0] <= fmt_ff;
      end else if (i_ahb.haddr[7:0] == usart_pkg::ADDR_BAUD) begin
        o_hrdata[BAUD_W-1:0] <= baud_ff;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_ff <= usart_pkg::CONTROL_RST;
      fmt_ff <= usart_pkg::FORMAT_RST;
      baud_ff <= BAUD_RST_W;
      dbl_ff <= 1'b0;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == usart_pkg::ADDR_CONTROL) begin
        ctrl_ff <= {i_hwdata[7:2], 1'b0, i_hwdata[0]};
      end else if (wr_addr_ff == usart_pkg::ADDR_FORMAT) begin
        fmt_ff <= i_hwdata[6:0];
      end else if (wr_addr_ff == usart_pkg::ADDR_BAUD) begin
        baud_ff <= i_hwdata[BAUD_W-1:0];
      end else if (wr_addr_ff == usart_pkg::ADDR_STATUS) begin
        dbl_ff <= i_hwdata[usart_pkg::ST_DOUBLE_SPEED];
      end
    end
  end

  // ----------------------------------------
  // Baud and serial clock
  // ----------------------------------------
  assign tick = baud_cnt_ff == '0;
  assign ovs = dbl_ff ? usart_pkg::OVS_DOUBLE : usart_pkg::OVS_NORMAL;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      baud_cnt_ff <= '0;
    end else begin
      baud_cnt_ff <= tick ? baud_ff : baud_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_xck <= 1'b0;
      o_xck_oe <= 1'b0;
    end else begin
      o_xck_oe <= cfg.sync_mode && (tx_own_ff || ctrl_ff[usart_pkg::CT_RX_ENABLE]);
      if (!cfg.sync_mode) begin
        o_xck <= 1'b0;
      end else if (tick) begin
        o_xck <= !o_xck;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  assign tx_step = cfg.sync_mode ? (tick && !o_xck) : (tick && tx_os_ff == ovs - 5'h01);
  assign tx_last = tx_busy_ff && tx_left_ff == 4'h1;
  assign tx_load = tx_step && tx_full_ff && tx_own_ff && (!tx_busy_ff || tx_last);
  assign tx_done_set = tx_step && tx_last && !tx_full_ff;
  assign tx_count = 4'h3 + cfg.nbits + {3'h0, cfg.parity_en} + {3'h0, cfg.stop_two} - 4'h1;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_os_ff <= 5'h00;
    end else if (tick) begin
      tx_os_ff <= (tx_os_ff >= ovs - 5'h01) ? 5'h00 : tx_os_ff + 5'h01;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_buf_ff <= 9'h000;
      tx_full_ff <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_buf_ff <= {ctrl_ff[usart_pkg::CT_TX_NINTH], i_hwdata[7:0]};
      end
      tx_full_ff <= wr_data || (tx_full_ff && !tx_load);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_busy_ff <= 1'b0;
      tx_left_ff <= 4'h0;
      tx_sh_ff <= '1;
      o_txd <= 1'b1;
    end else if (tx_load) begin
      {tx_sh_ff, o_txd} <= build_frame(tx_buf_ff, cfg);
      tx_left_ff <= tx_count;
      tx_busy_ff <= 1'b1;
    end else if (tx_step && tx_busy_ff) begin
      if (tx_last) begin
        tx_busy_ff <= 1'b0;
        o_txd <= 1'b1;
      end else begin
        o_txd <= tx_sh_ff[0];
        tx_sh_ff <= {1'b1, tx_sh_ff[11:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_done_ff <= 1'b0;
    end else if (tx_done_set) begin
      tx_done_ff <= 1'b1;
    end else if (i_tx_done_irq_taken || (wr_status && i_hwdata[usart_pkg::ST_TX_COMPLETE])) begin
      tx_done_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_own_ff <= 1'b0;
      o_txd_oe <= 1'b0;
    end else begin
      if (ctrl_ff[usart_pkg::CT_TX_ENABLE]) begin
        tx_own_ff <= 1'b1;
      end else if (!tx_busy_ff && !tx_full_ff) begin
        tx_own_ff <= 1'b0;
      end
      o_txd_oe <= ctrl_ff[usart_pkg::CT_TX_ENABLE] || (tx_own_ff && (tx_busy_ff || tx_full_ff));
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_empty_irq <= 1'b0;
      o_tx_done_irq <= 1'b0;
    end else begin
      o_tx_empty_irq <= i_global_irq_en && ctrl_ff[usart_pkg::CT_TX_EMPTY_IE] && !tx_full_ff;
      o_tx_done_irq <= i_global_irq_en && ctrl_ff[usart_pkg::CT_TX_COMPLETE_IE] && tx_done_ff;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  assign rx_total = cfg.nbits + {3'h0, cfg.parity_en} + 4'h1;
  assign rx_start = !rx_busy_ff && !i_rxd && (cfg.sync_mode ? (tick && o_xck) :
                    (tick && rx_os_ff == (ovs >> 1) - 5'h01));
  assign rx_sample = rx_busy_ff && tick && (cfg.sync_mode ? o_xck : rx_os_ff == ovs - 5'h01);
  assign rx_done = rx_sample && rx_left_ff == 4'h1;
  assign nxt_rx_sh = {i_rxd, rx_sh_ff[10:1]};
  assign rx_word = mask_data(9'(nxt_rx_sh >> (4'd11 - rx_total)), cfg.nbits);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_os_ff <= 5'h00;
    end else if (rx_start || rx_sample || (!rx_busy_ff && i_rxd)) begin
      rx_os_ff <= 5'h00;
    end else if (tick) begin
      rx_os_ff <= rx_os_ff + 5'h01;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_busy_ff <= 1'b0;
      rx_left_ff <= 4'h0;
      rx_sh_ff <= 11'h000;
    end else if (!ctrl_ff[usart_pkg::CT_RX_ENABLE]) begin
      rx_busy_ff <= 1'b0;
    end else if (rx_start) begin
      rx_busy_ff <= 1'b1;
      rx_left_ff <= rx_total;
    end else if (rx_sample) begin
      rx_sh_ff <= nxt_rx_sh;
      rx_left_ff <= rx_left_ff - 4'h1;
      rx_busy_ff <= !rx_done;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_buf_ff <= 9'h000;
      rx_full_ff <= 1'b0;
      o_rxd_owned <= 1'b0;
    end else begin
      o_rxd_owned <= ctrl_ff[usart_pkg::CT_RX_ENABLE];
      if (!ctrl_ff[usart_pkg::CT_RX_ENABLE]) begin
        rx_full_ff <= 1'b0;
      end else if (rx_done) begin
        rx_buf_ff <= rx_word;
        rx_full_ff <= 1'b1;
      end else if (rd_data) begin
        rx_full_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_load;
    tx_load;
  endsequence
  sequence s_start_bit;
    !o_txd && tx_busy_ff;
  endsequence
  property p_load_start;
    @(posedge i_sys_clk) disable iff (i_rst) s_load |=> s_start_bit;
  endproperty
  a_load_start: assert property (p_load_start) else $error("Load did not start frame");
  property p_idle_high;
    @(posedge i_sys_clk) disable iff (i_rst) !tx_busy_ff |-> o_txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("Idle line not high");
  property p_wr_full;
    @(posedge i_sys_clk) disable iff (i_rst) wr_data |=> tx_full_ff;
  endproperty
  a_wr_full: assert property (p_wr_full) else $error("Data write left buffer empty");
  property p_done_set;
    @(posedge i_sys_clk) disable iff (i_rst) tx_done_set |=> tx_done_ff && !tx_busy_ff;
  endproperty
  a_done_set: assert property (p_done_set) else $error("Complete flag missing");
  property p_done_clear;
    @(posedge i_sys_clk) disable iff (i_rst) i_tx_done_irq_taken && !tx_done_set |=> !tx_done_ff;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("Complete flag not cleared");
  property p_hold_pin;
    @(posedge i_sys_clk) disable iff (i_rst) tx_own_ff && (tx_busy_ff || tx_full_ff) |=> o_txd_oe;
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("Pin released early");
  property p_empty_irq;
    @(posedge i_sys_clk) disable iff (i_rst)
      i_global_irq_en && ctrl_ff[usart_pkg::CT_TX_EMPTY_IE] && !tx_full_ff |=> o_tx_empty_irq;
  endproperty
  a_empty_irq: assert property (p_empty_irq) else $error("Empty request missing");
  property p_rx_flush;
    @(posedge i_sys_clk) disable iff (i_rst) !ctrl_ff[usart_pkg::CT_RX_ENABLE] |=> !rx_full_ff;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("Receive buffer not flushed");
  property p_rx_done;
    @(posedge i_sys_clk) disable iff (i_rst)
      rx_done && ctrl_ff[usart_pkg::CT_RX_ENABLE] |=> rx_full_ff && rx_buf_ff == $past(rx_word);
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("Frame not moved to buffer");
  property p_parity;
    @(posedge i_sys_clk) disable iff (i_rst)
      tx_load && cfg.parity_en |=>
      tx_sh_ff[cfg.nbits] == ((^$past(mask_data(tx_buf_ff, cfg.nbits))) ^ cfg.parity_odd);
  endproperty
  a_parity: assert property (p_parity) else $error("Parity bit wrong");
endmodule

// ### testbench/usart_partner.sv
module usart_partner (
  // Clock
  input wire logic i_clk,
  // Serial line
  input wire logic i_txd,
  input wire logic i_txd_oe,
  output logic o_rxd,
  // Frame format and bit time
  input wire usart_pkg::frame_cfg_t i_cfg,
  input wire logic [7:0] i_bit_clks,
  // Last captured frame
  output logic [8:0] o_word,
  output logic o_ok,
  output logic [7:0] o_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] bits;
  logic par;
  int k;
  int len;
  initial begin
    o_rxd = 1'b1;
    o_word = 9'h000;
    o_ok = 1'b0;
    o_count = 8'h00;
  end
  // ----------------------------------------
  // Capture of transmitted frames
  // ----------------------------------------
  initial forever begin
    @(posedge i_clk);
    if (i_txd_oe === 1'b1 && i_txd === 1'b0) begin
      len = i_cfg.nbits + i_cfg.parity_en + 1 + i_cfg.stop_two;
      repeat (i_bit_clks / 2) @(posedge i_clk);
      for (k = 0; k < len; k++) begin
        repeat (i_bit_clks) @(posedge i_clk);
        bits[k] = i_txd;
      end
      par = i_cfg.parity_odd;
      o_word = 9'h000;
      for (k = 0; k < i_cfg.nbits; k++) begin
        o_word[k] = bits[k];
        par = par ^ bits[k];
      end
      o_ok = (bits[i_cfg.nbits] === (i_cfg.parity_en ? par : 1'b1)) &&
        (bits[i_cfg.nbits + i_cfg.parity_en] === 1'b1) && (bits[len - 1] === 1'b1);
      o_count = o_count + 8'h01;
    end
  end
  // ----------------------------------------
  // Launch of frames toward the receiver
  // ----------------------------------------
  task automatic send(input logic [8:0] d);
    logic [12:0] f;
    logic p;
    int j;
    f = 13'h1fff;
    f[0] = 1'b0;
    p = i_cfg.parity_odd;
    for (j = 0; j < i_cfg.nbits; j++) begin
      f[j + 1] = d[j];
      p = p ^ d[j];
    end
    if (i_cfg.parity_en) f[i_cfg.nbits + 1] = p;
    for (j = 0; j < i_cfg.nbits + i_cfg.parity_en + 2 + i_cfg.stop_two; j++) begin
      @(posedge i_clk);
      o_rxd <= f[j];
      repeat (i_bit_clks - 1) @(posedge i_clk);
    end
  endtask
endmodule

// ### testbench/test_usart_tx_rx_framing.sv
module test_usart_tx_rx_framing;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sel = 1'b0;
  logic wr_en = 1'b0;
  logic [1:0] trans = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic gie = 1'b0;
  logic irq_taken = 1'b0;
  logic [7:0] bit_clks = 8'h10;
  usart_pkg::frame_cfg_t cfg = 8'h58;
  usart_pkg::ahb_req_t ahb;
  logic [31:0] hrdata, r;
  logic [1:0] hresp;
  logic hreadyout, txd, txd_oe, rxd, rxd_owned, serial_clock_pin, xck_oe, empty_irq, done_irq, p_ok;
  logic [8:0] p_word;
  logic [7:0] p_count;
  int bad_count = 0;
  int check_count = 0;
  assign ahb = '{hsel: sel, haddr: {24'h0, addr}, htrans: trans, hwrite: wr_en, hsize: 3'h2, hready: hreadyout};
  always #4 i_sys_clk = ~i_sys_clk;
  usart_tx_rx_framing usart_tx_rx_framing_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ahb(ahb),
    .i_hwdata(wdata), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_txd(txd),
    .o_txd_oe(txd_oe), .i_rxd(rxd), .o_rxd_owned(rxd_owned), .i_xck(1'b0), .o_xck(serial_clock_pin), .o_xck_oe(xck_oe),
    .i_global_irq_en(gie), .i_tx_done_irq_taken(irq_taken), .o_tx_empty_irq(empty_irq),
    .o_tx_done_irq(done_irq));
  usart_partner usart_partner_i (.i_clk(i_sys_clk), .i_txd(txd), .i_txd_oe(txd_oe), .o_rxd(rxd),
    .i_cfg(cfg), .i_bit_clks(bit_clks), .o_word(p_word), .o_ok(p_ok), .o_count(p_count));
  // ----------------------------------------
  // Report and bus tasks
  // ----------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task give_up;
    bad_count++;
    $display("mismatch wait expected done seen timeout");
    summarize;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wait_ready(inout int n);
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    sel <= 1'b1;
    trans <= usart_pkg::HTRANS_NONSEQ;
    wr_en <= w;
    addr <= a;
    wait_ready(n);
    sel <= 1'b0;
    trans <= 2'h0;
    wdata <= d;
    wait_ready(n);
    r = hrdata;
    if (n >= 50) give_up;
    chk("hresp", 32'h0, {30'h0, hresp});
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task wait_bit(input int b);
    int n;
    for (n = 0; n < 600; n++) begin
      rd(usart_pkg::ADDR_STATUS);
      if (r[b] === 1'b1) return;
    end
    give_up;
  endtask
  task wait_frames(input logic [7:0] c);
    int n;
    for (n = 0; n < 3000 && p_count !== c; n++) @(posedge i_sys_clk);
    if (p_count !== c) give_up;
  endtask
  task automatic wait_cycles_for(ref logic s, input logic v);
    int n;
    for (n = 0; n < 200 && s !== v; n++) @(posedge i_sys_clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    chk("txd idle", 32'h1, {31'h0, txd});
    chk("txd owner", 32'h0, {31'h0, txd_oe});
    rd(usart_pkg::ADDR_STATUS);
    chk("status", 32'h20, r);
    rd(usart_pkg::ADDR_FORMAT);
    chk("format", 32'h06, r);
    rd(usart_pkg::ADDR_CONTROL);
    chk("control", 32'h00, r);
    wr(8'h14, 32'hff);
    rd(8'h14);
    chk("unmapped", 32'h0, r);
  endtask
  task t_tx8;
    wr(usart_pkg::ADDR_BAUD, 32'h0);
    wr(usart_pkg::ADDR_FORMAT, 32'h2e);
    wr(usart_pkg::ADDR_CONTROL, 32'h18);
    repeat (2) @(posedge i_sys_clk);
    chk("txd owner", 32'h1, {31'h0, txd_oe});
    chk("rxd owner", 32'h1, {31'h0, rxd_owned});
    wr(usart_pkg::ADDR_DATA, 32'ha5);
    wait_bit(usart_pkg::ST_TX_EMPTY);
    wr(usart_pkg::ADDR_DATA, 32'h3c);
    rd(usart_pkg::ADDR_STATUS);
    chk("status busy", 32'h00, r);
    wait_frames(8'h01);
    chk("frame a", 32'h0a5, {23'h0, p_word});
    chk("frame a ok", 32'h1, {31'h0, p_ok});
    wait_frames(8'h02);
    chk("frame b", 32'h03c, {23'h0, p_word});
    wait_bit(usart_pkg::ST_TX_COMPLETE);
    wr(usart_pkg::ADDR_STATUS, 32'h40);
    rd(usart_pkg::ADDR_STATUS);
    chk("complete cleared", 32'h20, r);
    usart_partner_i.send(9'h0c3);
    wait_bit(usart_pkg::ST_RX_COMPLETE);
    rd(usart_pkg::ADDR_DATA);
    chk("rx data", 32'hc3, r);
    rd(usart_pkg::ADDR_STATUS);
    chk("rx read", 32'h20, r);
  endtask
  task t_irq;
    gie <= 1'b1;
    wr(usart_pkg::ADDR_CONTROL, 32'h78);
    wait_cycles_for(empty_irq, 1'b1);
    chk("empty irq", 32'h1, {31'h0, empty_irq});
    chk("done irq idle", 32'h0, {31'h0, done_irq});
    wr(usart_pkg::ADDR_DATA, 32'h55);
    wait_frames(8'h03);
    wait_cycles_for(done_irq, 1'b1);
    chk("done irq", 32'h1, {31'h0, done_irq});
    irq_taken <= 1'b1;
    @(posedge i_sys_clk);
    irq_taken <= 1'b0;
    wait_cycles_for(done_irq, 1'b0);
    rd(usart_pkg::ADDR_STATUS);
    chk("taken clears", 32'h20, r);
    wr(usart_pkg::ADDR_CONTROL, 32'h18);
    gie <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    chk("empty irq off", 32'h0, {31'h0, empty_irq});
  endtask
  task t_short;
    wr(usart_pkg::ADDR_FORMAT, 32'h00);
    wr(usart_pkg::ADDR_STATUS, 32'h02);
    bit_clks <= 8'h08;
    cfg = 8'h05;
    wr(usart_pkg::ADDR_DATA, 32'hff);
    wait_frames(8'h04);
    chk("short tx", 32'h01f, {23'h0, p_word});
    chk("short ok", 32'h1, {31'h0, p_ok});
    usart_partner_i.send(9'h1ff);
    wait_bit(usart_pkg::ST_RX_COMPLETE);
    rd(usart_pkg::ADDR_DATA);
    chk("short rx", 32'h1f, r);
    usart_partner_i.send(9'h00a);
    wait_bit(usart_pkg::ST_RX_COMPLETE);
    wr(usart_pkg::ADDR_CONTROL, 32'h08);
    rd(usart_pkg::ADDR_STATUS);
    chk("flush", 32'h62, r);
    chk("rxd released", 32'h0, {31'h0, rxd_owned});
    wr(usart_pkg::ADDR_STATUS, 32'h00);
    bit_clks <= 8'h10;
  endtask
  task t_nine;
    cfg = 8'h69;
    wr(usart_pkg::ADDR_FORMAT, 32'h36);
    wr(usart_pkg::ADDR_CONTROL, 32'h1d);
    wr(usart_pkg::ADDR_DATA, 32'ha5);
    wait_frames(8'h05);
    chk("nine tx", 32'h1a5, {23'h0, p_word});
    chk("odd parity", 32'h1, {31'h0, p_ok});
    usart_partner_i.send(9'h15a);
    wait_bit(usart_pkg::ST_RX_COMPLETE);
    rd(usart_pkg::ADDR_CONTROL);
    chk("rx ninth", 32'h1, {31'h0, r[usart_pkg::CT_RX_NINTH]});
    rd(usart_pkg::ADDR_DATA);
    chk("nine rx", 32'h5a, r);
  endtask
  task t_disable;
    wr(usart_pkg::ADDR_DATA, 32'h33);
    wr(usart_pkg::ADDR_CONTROL, 32'h04);
    repeat (2) @(posedge i_sys_clk);
    chk("held owner", 32'h1, {31'h0, txd_oe});
    wait_frames(8'h06);
    wait_cycles_for(txd_oe, 1'b0);
    chk("released", 32'h0, {31'h0, txd_oe});
    chk("last frame", 32'h133, {23'h0, p_word});
    wr(usart_pkg::ADDR_FORMAT, 32'h40);
    wr(usart_pkg::ADDR_CONTROL, 32'h10);
    repeat (2) @(posedge i_sys_clk);
    chk("xck owner", 32'h1, {31'h0, xck_oe});
    r = {31'h0, serial_clock_pin};
    @(posedge i_sys_clk);
    chk("xck toggles", {31'h0, ~r[0]}, {31'h0, serial_clock_pin});
    wr(usart_pkg::ADDR_CONTROL, 32'h00);
    repeat (2) @(posedge i_sys_clk);
    chk("xck released", 32'h0, {31'h0, xck_oe});
  endtask
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_reset;
    t_tx8;
    t_irq;
    t_short;
    t_nine;
    t_disable;
    summarize;
  end
endmodule
